// file: fts_pkg.sv
// Package for the flow-through burst SRAM bus model: widths, timing counts,
// the sampled bus bundle and the cycle-kind enumeration.
// Assumes a single 250 MHz clock and the bus partner meeting its own duties.
// Summary of operation
// - The device is selected only with first enable low, second high and third low.
// - A full write starts on global write low, or with lane gate low and every lane enable low.
// - After a write the data outputs stay off until a new read is started by either strobe.
// - On leaving sleep the data pins are in high impedance.
// - Data pins follow the current cycle and an unclocked output enable masked during writes.
// - Outside sleep, a processor strobe with the device selected starts a read whatever the write controls say.
// - With global write high and lane gate low, exactly the lanes whose enables are low are written.
package fts_pkg;

    localparam int ADDR_W = 18;
    localparam int LANES = 4;
    localparam int LANE_W = 9;
    localparam int DATA_W = LANES * LANE_W;
    localparam int DEPTH = 1 << ADDR_W;
    localparam int BURST_W = 2;

    // Power-up hold-off, kept by the partner; exported for reference only
    localparam int CLK_MHZ = 250;
    localparam int POWER_UP_MS = 1;
    localparam int POWER_UP_CYC = POWER_UP_MS * 1000 * CLK_MHZ;

    localparam logic [BURST_W-1:0] BURST_ONE = 2'h1;
    localparam logic [LANES-1:0] LANES_NONE = 4'h0;
    localparam logic [LANES-1:0] LANES_ALL = 4'hF;

    typedef enum logic [1:0] {
        FTS_IDLE,
        FTS_READ,
        FTS_WRITE
    } fts_cycle_t;

    typedef struct packed {
        logic chip_sel_first_n;
        logic chip_sel_second_hi;
        logic chip_sel_third_n;
        logic processor_addr_strobe_n;
        logic controller_addr_strobe_n;
        logic advance_n;
        logic global_write_n;
        logic lane_write_gate_n;
        logic [LANES-1:0] lane_write_n;
    } fts_ctrl_t;

endpackage

// file: fts_lane_store.sv
`timescale 1ns/1ps
// One byte lane (eight data bits plus parity) of the storage array.
// Assumes address and write strobe are already registered by the caller.
module fts_lane_store
(
    input wire logic clock,
    input wire logic write_en,
    input wire logic [fts_pkg::ADDR_W-1:0] addr,
    input wire logic [fts_pkg::LANE_W-1:0] wdata,
    output logic [fts_pkg::LANE_W-1:0] rdata
);

    logic [fts_pkg::LANE_W-1:0] mem [fts_pkg::DEPTH];

    // No reset on the array: contents are undefined after power-up like real SRAM
    always_ff @(posedge clock)
    begin
        if (write_en)
        begin
            mem[addr] <= wdata;
        end
    end

    assign rdata = mem[addr];

endmodule

// file: fts_sram_core.sv
`timescale 1ns/1ps
// Bus-side behaviour of a flow-through burst SRAM: chip select decode,
// read/write cycle control, byte-lane writes, burst counter and sleep.
// Assumes all controls are synchronous to clock except output_enable_n and
// sleep_request, which act without sampling and are combined on the output.
module fts_sram_core
(
    input wire logic clock,
    input wire logic reset_n,
    input wire fts_pkg::fts_ctrl_t ctrl,
    input wire logic burst_linear,
    input wire logic [fts_pkg::ADDR_W-1:0] addr,
    input wire logic [fts_pkg::DATA_W-1:0] data_in,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    output logic [fts_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    output logic asleep
);

    // ------------------------------------------------------------
    // Input decode
    // ------------------------------------------------------------
    logic selected;
    logic proc_start;
    logic ctrl_start;
    logic any_write;
    logic [fts_pkg::LANES-1:0] lanes_next;

    assign selected = !ctrl.chip_sel_first_n && ctrl.chip_sel_second_hi
        && !ctrl.chip_sel_third_n;
    // Processor strobe only counts while the first enable is low
    assign proc_start = !ctrl.processor_addr_strobe_n && !ctrl.chip_sel_first_n;
    assign ctrl_start = !ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n;

    always_comb
    begin
        if (!ctrl.global_write_n)
        begin
            lanes_next = fts_pkg::LANES_ALL;
        end
        else if (!ctrl.lane_write_gate_n)
        begin
            lanes_next = ~ctrl.lane_write_n;
        end
        else
        begin
            lanes_next = fts_pkg::LANES_NONE;
        end
    end
    assign any_write = (lanes_next != fts_pkg::LANES_NONE);

    // ------------------------------------------------------------
    // Cycle state, burst address and write data registers
    // ------------------------------------------------------------
    fts_pkg::fts_cycle_t cycle_reg;
    logic [fts_pkg::ADDR_W-1:0] base_reg;
    logic [fts_pkg::BURST_W-1:0] count_reg;
    logic [fts_pkg::LANES-1:0] lanes_reg;
    logic [fts_pkg::DATA_W-1:0] wdata_reg;
    logic asleep_reg;

    // All synchronous controls are taken on the rising edge only
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cycle_reg <= fts_pkg::FTS_IDLE;
        end
        else if (sleep_request)
        begin
            // Sleep drops the cycle so outputs are off on wake-up
            cycle_reg <= fts_pkg::FTS_IDLE;
        end
        else if (proc_start)
        begin
            cycle_reg <= selected ? fts_pkg::FTS_READ : fts_pkg::FTS_IDLE;
        end
        else if (ctrl_start)
        begin
            if (!selected)
            begin
                cycle_reg <= fts_pkg::FTS_IDLE;
            end
            else
            begin
                cycle_reg <= any_write ? fts_pkg::FTS_WRITE : fts_pkg::FTS_READ;
            end
        end
        else if (cycle_reg != fts_pkg::FTS_IDLE)
        begin
            // Continuing cycle: writes may follow a processor-strobe read
            // A write leaves outputs off until a new strobe starts a read
            cycle_reg <= any_write ? fts_pkg::FTS_WRITE : cycle_reg;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            base_reg <= '0;
            count_reg <= '0;
        end
        else if (!sleep_request && (proc_start || ctrl_start))
        begin
            base_reg <= addr;
            count_reg <= addr[fts_pkg::BURST_W-1:0];
        end
        else if (!sleep_request && !ctrl.advance_n && cycle_reg != fts_pkg::FTS_IDLE)
        begin
            count_reg <= count_reg + fts_pkg::BURST_ONE;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lanes_reg <= fts_pkg::LANES_NONE;
            wdata_reg <= '0;
        end
        else
        begin
            // Processor strobe forces a read, so no lane is written with it
            if (sleep_request || proc_start || (ctrl_start && !selected))
            begin
                lanes_reg <= fts_pkg::LANES_NONE;
            end
            else if (ctrl_start || cycle_reg != fts_pkg::FTS_IDLE)
            begin
                lanes_reg <= lanes_next;
            end
            else
            begin
                lanes_reg <= fts_pkg::LANES_NONE;
            end
            wdata_reg <= data_in;
        end
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            asleep_reg <= 1'b0;
        end
        else
        begin
            asleep_reg <= sleep_request;
        end
    end

    // ------------------------------------------------------------
    // Burst address and storage
    // ------------------------------------------------------------
    logic [fts_pkg::BURST_W-1:0] burst_bits;
    logic [fts_pkg::ADDR_W-1:0] cur_addr;

    // Interleaved order is an XOR of the start offset with the step count
    always_comb
    begin
        if (burst_linear)
        begin
            burst_bits = count_reg;
        end
        else
        begin
            burst_bits = base_reg[fts_pkg::BURST_W-1:0]
                ^ (count_reg - base_reg[fts_pkg::BURST_W-1:0]);
        end
    end
    assign cur_addr = {base_reg[fts_pkg::ADDR_W-1:fts_pkg::BURST_W], burst_bits};

    logic [fts_pkg::DATA_W-1:0] rdata;

    for (genvar i = 0; i < fts_pkg::LANES; i++)
    begin : g_lane
        fts_lane_store u_lane
        (
            .clock(clock),
            .write_en(lanes_reg[i] && cycle_reg == fts_pkg::FTS_WRITE),
            .addr(cur_addr),
            .wdata(wdata_reg[i*fts_pkg::LANE_W +: fts_pkg::LANE_W]),
            .rdata(rdata[i*fts_pkg::LANE_W +: fts_pkg::LANE_W])
        );
    end

    // ------------------------------------------------------------
    // Output stage
    // ------------------------------------------------------------
    // Flow-through data is registered; the enable is gated without a clock
    // because output enable and sleep act asynchronously on the pins.
    logic [fts_pkg::DATA_W-1:0] dout_reg;
    logic drive_reg;

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            dout_reg <= '0;
            drive_reg <= 1'b0;
        end
        else
        begin
            dout_reg <= rdata;
            drive_reg <= (cycle_reg == fts_pkg::FTS_READ) && !any_write;
        end
    end

    assign data_out = dout_reg;
    // Write cycles mask output enable; sleep forces high impedance
    assign data_oe = drive_reg && !output_enable_n && !sleep_request
        && cycle_reg != fts_pkg::FTS_WRITE;
    assign asleep = asleep_reg;

endmodule

// file: fts_sram_core_properties.sv
`timescale 1ns/1ps
// Bus-rule assertions for the flow-through SRAM core.
// Assumes one clock domain; bound to every core instance.
module fts_sram_core_properties
(
    input wire logic clock,
    input wire logic reset_n,
    input wire fts_pkg::fts_ctrl_t ctrl,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic data_oe,
    input wire logic asleep
);
    wire logic sel = !ctrl.chip_sel_first_n && ctrl.chip_sel_second_hi && !ctrl.chip_sel_third_n;
    wire logic quiet = ctrl.processor_addr_strobe_n && ctrl.controller_addr_strobe_n;
    wire logic rd_go = sel && !ctrl.processor_addr_strobe_n && !output_enable_n;
    wire logic wr_go = sel && !ctrl.controller_addr_strobe_n && ctrl.processor_addr_strobe_n
        && !ctrl.global_write_n;
    wire logic hold = quiet && !output_enable_n && !sleep_request;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property drives(start);
        start ##1 hold[*2] |-> data_oe;
    endproperty
    oe_gate_a: assert property (output_enable_n |-> !data_oe)
        else $error("data driven with output enable high");
    sleep_gate_a: assert property (sleep_request |-> !data_oe)
        else $error("data driven while asleep");
    read_drive_a: assert property (drives(rd_go))
        else $error("read did not drive data");
    strobe_wins_a: assert property (drives(rd_go && !ctrl.global_write_n))
        else $error("write controls blocked a strobed read");
    deselect_quiet_a: assert property (!quiet && !sel ##1 quiet |-> ##1 !data_oe)
        else $error("deselected strobe drove data");
    write_quiet_a: assert property (wr_go ##1 quiet[*2] |-> !data_oe)
        else $error("data driven after write");
    sleep_track_a: assert property ($rose(sleep_request) |=> asleep)
        else $error("sleep state not taken");
    wake_quiet_a: assert property ($fell(asleep) |-> !data_oe)
        else $error("data driven on wake");
    cover property (wr_go);
    cover property (!quiet && !sel);
    cover property ($fell(asleep));
endmodule
bind fts_sram_core fts_sram_core_properties chk (.clock(clock), .reset_n(reset_n), .ctrl(ctrl),
    .output_enable_n(output_enable_n), .sleep_request(sleep_request), .data_oe(data_oe),
    .asleep(asleep));

// file: fts_bus_host.sv
`timescale 1ns/1ps
// Processor-side bus model: issues one strobed cycle at a time.
// Assumes the core samples its controls on the rising clock edge.
module fts_bus_host
#(
    parameter int WAIT_CYC = 16
)
(
    input wire logic clock,
    output fts_pkg::fts_ctrl_t ctrl,
    output logic [fts_pkg::ADDR_W-1:0] addr,
    output logic [fts_pkg::DATA_W-1:0] data_in,
    output logic output_enable_n,
    output logic sleep_request
);
    // Deselected with every strobe and write control released
    localparam logic [11:0] IDLE = 12'hBFF;
    initial
    begin
        ctrl = IDLE;
        addr = '0;
        data_in = '0;
        output_enable_n = 1'b1;
        sleep_request = 1'b0;
    end
    // Power-up hold-off, shortened so the run stays brief
    task automatic settle();
        repeat (WAIT_CYC) @(negedge clock);
    endtask
    task automatic op(input logic [11:0] c, input logic [fts_pkg::ADDR_W-1:0] a,
        input logic [fts_pkg::DATA_W-1:0] d);
        @(negedge clock);
        ctrl <= c;
        addr <= a;
        data_in <= d;
        output_enable_n <= c[8];
        @(negedge clock);
        ctrl <= IDLE;
        // Released lines do not keep their last value
        addr <= ~a;
        data_in <= ~d;
        repeat (2) @(negedge clock);
        output_enable_n <= 1'b1;
    endtask
    task automatic nap();
        @(negedge clock);
        ctrl <= IDLE;
        sleep_request <= 1'b1;
        repeat (4) @(negedge clock);
        sleep_request <= 1'b0;
    endtask
endmodule

// file: testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the flow-through SRAM core.
// Assumes the host model and checker are compiled first.
module testbench;
    logic clock;
    logic reset_n;
    logic burst_linear;
    fts_pkg::fts_ctrl_t ctrl;
    logic [fts_pkg::ADDR_W-1:0] addr;
    logic [fts_pkg::ADDR_W-1:0] ad;
    logic [fts_pkg::DATA_W-1:0] data_in;
    logic [fts_pkg::DATA_W-1:0] data_out;
    logic [fts_pkg::DATA_W-1:0] mem_a;
    logic [fts_pkg::DATA_W-1:0] m;
    logic [fts_pkg::DATA_W-1:0] expect_q[$];
    logic output_enable_n;
    logic sleep_request;
    logic data_oe;
    logic asleep;
    logic seen_oe;
    int n_fail;
    int checks;
    fts_bus_host host (.clock(clock), .ctrl(ctrl), .addr(addr), .data_in(data_in),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request));
    fts_sram_core uut (.clock(clock), .reset_n(reset_n), .ctrl(ctrl),
        .burst_linear(burst_linear), .addr(addr), .data_in(data_in),
        .output_enable_n(output_enable_n), .sleep_request(sleep_request),
        .data_out(data_out), .data_oe(data_oe), .asleep(asleep));
    function automatic logic [fts_pkg::DATA_W-1:0] rnd();
        return fts_pkg::DATA_W'({$urandom, $urandom});
    endfunction
    task automatic wr(input logic [11:0] c, input logic [fts_pkg::DATA_W-1:0] d);
        for (int k = 0; k < fts_pkg::LANES; k++)
            if (c[11:9] == 3'b010 && (!c[5] || (!c[4] && !c[k])))
                mem_a[9*k +: 9] = d[9*k +: 9];
        host.op(c, ad, d);
    endtask
    task automatic rd(input logic [11:0] c);
        if (c[11:9] == 3'b010)
            expect_q.push_back(mem_a);
        host.op(c, ad, rnd());
    endtask
    task automatic wrap_up();
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end
    // Each rising data drive is one read answer
    always @(negedge clock)
    begin
        if (data_oe === 1'b1 && seen_oe !== 1'b1)
        begin
            checks++;
            m = (expect_q.size() > 0) ? expect_q.pop_front() : 'x;
            if (data_out !== m)
            begin
                n_fail++;
                $display("unexpected data_out: expected %h seen %h", m, data_out);
            end
        end
        seen_oe = data_oe;
    end
    initial
    begin
        repeat (5000) @(posedge clock);
        n_fail++;
        wrap_up();
    end
    initial
    begin
        reset_n = 1'b0;
        burst_linear = 1'b1;
        n_fail = 0;
        checks = 0;
        seen_oe = 1'b0;
        mem_a = '0;
        void'($urandom(32'hED51D87E));
        ad = fts_pkg::ADDR_W'($urandom);
        repeat (2) @(negedge clock);
        reset_n = 1'b1;
        host.settle();
        for (int i = 0; i < 16; i++)
        begin
            wr(12'h55F, rnd());
            rd(12'h4FF);
            wr({8'h56, 4'(i)}, rnd());
            rd(12'h4C0);
        end
        // Interleaved order must give the same start word as linear order
        burst_linear = 1'b0;
        for (int s = 0; s < 8; s++)
        begin
            wr({3'(s), 9'h15F}, rnd());
            rd({3'(s), 9'h0FF});
        end
        host.nap();
        checks++;
        if (asleep !== 1'b1)
        begin
            n_fail++;
            $display("unexpected asleep: expected 1 seen %b", asleep);
        end
        repeat (2) @(negedge clock);
        checks++;
        if (asleep !== 1'b0)
        begin
            n_fail++;
            $display("unexpected asleep: expected 0 seen %b", asleep);
        end
        checks++;
        if (data_oe !== 1'b0)
        begin
            n_fail++;
            $display("unexpected data_oe: expected 0 seen %b", data_oe);
        end
        rd(12'h4FF);
        repeat (3) @(negedge clock);
        checks++;
        if (expect_q.size() != 0)
        begin
            n_fail++;
            $display("unexpected reads left: expected 0 seen %0d", expect_q.size());
        end
        wrap_up();
    end
endmodule
